/* core/jtag_instruction_and_data_regs.v */
// instruction register, opcode decode and data register selection
`timescale 1ns/1ps
`include "jtag_ir_dr_map.vh"

// How it works
// - four-bit instruction stage loads serially from tdi during instruction shift.
// - test-logic reset puts 0010, the identification opcode, in the register.
// - the current opcode picks bypass, identification or boundary path.
// - opcode 1111 selects the one-bit bypass register.
// - opcode 0000 selects the boundary chain for interconnect test.
// - opcode 0001 selects the boundary chain to sample or preload.
// - opcode 0010 selects the identification register.
// - opcode 1001 selects boundary chain and single-step internal logic.
// - opcode 1000 floats device pins and selects bypass.
// - bypass register is one bit, the shortest path.
// - identification is 32 bits: version, part number, maker code and a presence bit.
// - first bit out after reset is that presence bit.
// - capture-data loads zero into the bypass register.
// - capture-instruction loads 0001 into the instruction stage.
// - new opcode reaches the register only at update, on falling tck.
// - shift-data advances the active register on rising tck.
module jtag_instruction_and_data_regs #(
    parameter [3:0]  VERSION_FIELD     = 4'h0,     // arbitrary value
    parameter [15:0] PART_NUMBER_FIELD = 16'h0ABC, // arbitrary value
    parameter [10:0] MAKER_CODE_FIELD  = 11'h055   // arbitrary value
) (
    input  wire       sys_clk_i,
    input  wire       srst_i,
    input  wire       tck_i,
    input  wire       tdi_i,
    input  wire       trst_n_i,
    input  wire       test_logic_reset_i,
    input  wire       capture_ir_i,
    input  wire       shift_ir_i,
    input  wire       update_ir_i,
    input  wire       capture_dr_i,
    input  wire       shift_dr_i,
    input  wire       bound_so_i,
    output reg        tdo_o,
    output reg  [3:0] instruction_opcode_field_o,
    output reg  [1:0] dr_select_o,
    output reg        bound_select_o,
    output reg        pins_highz_o,
    output reg        single_step_o,
    output reg        extest_o
);
    wire        tck_rise;
    wire        tck_fall;
    reg         trst_s1;
    reg         trst_s2;
    reg         tdi_s1;
    reg         tdi_s2;
    reg         tlr_s1;
    reg         tlr_s2;
    reg         cir_s1;
    reg         cir_s2;
    reg         sir_s1;
    reg         sir_s2;
    reg         uir_s1;
    reg         uir_s2;
    reg         cdr_s1;
    reg         cdr_s2;
    reg         sdr_s1;
    reg         sdr_s2;
    reg         bso_s1;
    reg         bso_s2;
    reg   [3:0] ir_shift;
    reg         bypass_bit;
    reg  [31:0] id_shift;
    reg  [1:0]  sel;
    reg  [3:0]  test_instruction_register;
    reg         next_tdo;
    wire [31:0] id_value;

    // decode of an opcode to its data register, used for the live path
    function [1:0] dr_of;
        input [3:0] op;
        begin
            if (op == `OP_EXTEST || op == `OP_SAMPLE || op == `OP_INTEST)
                dr_of = `SEL_BOUND;
            else if (op == `OP_DEVICE_IDENTIFICATION_REGISTER)
                dr_of = `SEL_IDENT;
            else
                dr_of = `SEL_BYPASS;  // bypass, highz and reserved
        end
    endfunction

    // tck is only sampled, never used as a clock; its edges arrive three clocks late
    tck_edge_detect u_tck (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .tck_i     (tck_i),
        .rise_o    (tck_rise),
        .fall_o    (tck_fall)
    );

    // identification word built field by field, presence bit fixed high
    assign id_value[`ID_VER_MSB:`ID_VER_LSB] = VERSION_FIELD;
    assign id_value[`ID_PN_MSB:`ID_PN_LSB]   = PART_NUMBER_FIELD;
    assign id_value[`ID_MFR_MSB:`ID_MFR_LSB] = MAKER_CODE_FIELD;
    assign id_value[`ID_PRESENT_BIT]         = 1'b1;

    // pin-side strobes pass two flops before use
    // tck edges come one flop later, so state and data line up with them
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            // system reset leaves test reset deasserted, so only the pin can force it
            trst_s1 <= 1'b1;
            trst_s2 <= 1'b1;
            tdi_s1  <= 1'b0;
            tdi_s2  <= 1'b0;
            tlr_s1  <= 1'b0;
            tlr_s2  <= 1'b0;
            cir_s1  <= 1'b0;
            cir_s2  <= 1'b0;
            sir_s1  <= 1'b0;
            sir_s2  <= 1'b0;
            uir_s1  <= 1'b0;
            uir_s2  <= 1'b0;
            cdr_s1  <= 1'b0;
            cdr_s2  <= 1'b0;
            sdr_s1  <= 1'b0;
            sdr_s2  <= 1'b0;
            bso_s1  <= 1'b0;
            bso_s2  <= 1'b0;
        end else begin
            trst_s1 <= trst_n_i;
            trst_s2 <= trst_s1;
            tdi_s1  <= tdi_i;
            tdi_s2  <= tdi_s1;
            tlr_s1  <= test_logic_reset_i;
            tlr_s2  <= tlr_s1;
            cir_s1  <= capture_ir_i;
            cir_s2  <= cir_s1;
            sir_s1  <= shift_ir_i;
            sir_s2  <= sir_s1;
            uir_s1  <= update_ir_i;
            uir_s2  <= uir_s1;
            cdr_s1  <= capture_dr_i;
            cdr_s2  <= cdr_s1;
            sdr_s1  <= shift_dr_i;
            sdr_s2  <= sdr_s1;
            bso_s1  <= bound_so_i;
            bso_s2  <= bso_s1;
        end
    end

    // instruction stage and parallel register
    // a test reset overrides any scan in flight
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            ir_shift                  <= `IR_CAPTURE;
            test_instruction_register <= `IR_RESET;
        end else if (!trst_s2 || tlr_s2) begin
            ir_shift                  <= `IR_CAPTURE;
            test_instruction_register <= `IR_RESET;
        end else begin
            if (tck_rise && cir_s2)
                ir_shift <= `IR_CAPTURE;
            else if (tck_rise && sir_s2)
                ir_shift <= {tdi_s2, ir_shift[3:1]};             // lsb out first
            if (tck_fall && uir_s2)
                test_instruction_register <= ir_shift;
        end
    end

    // data registers: bypass and identification shift stages
    // the boundary chain shifts outside; only its serial out is read here
    always @(posedge sys_clk_i) begin
        if (srst_i || !trst_s2 || tlr_s2) begin
            bypass_bit <= `BYPASS_CAPTURE;
            id_shift   <= id_value;   // presence bit leaves first after reset
        end else if (tck_rise && cdr_s2) begin
            bypass_bit <= `BYPASS_CAPTURE;
            id_shift   <= id_value;
        end else if (tck_rise && sdr_s2) begin
            if (sel == `SEL_BYPASS)
                bypass_bit <= tdi_s2;                            // one stage only
            if (sel == `SEL_IDENT)
                id_shift <= {tdi_s2, id_shift[31:1]};
        end
    end

    // serial output source
    // instruction stage wins only while shift_ir is high
    always @* begin
        sel = dr_of(test_instruction_register);
        if (sir_s2)
            next_tdo = ir_shift[0];
        else if (sel == `SEL_IDENT)
            next_tdo = id_shift[0];
        else if (sel == `SEL_BOUND)
            next_tdo = bso_s2;
        else
            next_tdo = bypass_bit;
    end

    // registered outputs; tdo changes only on falling tck like a real port
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            tdo_o                      <= 1'b1;   // idles high until the first falling tck
            instruction_opcode_field_o <= `IR_RESET;
            dr_select_o                <= `SEL_IDENT;
            bound_select_o             <= 1'b0;
            pins_highz_o               <= 1'b0;
            single_step_o              <= 1'b0;
            extest_o                   <= 1'b0;
        end else begin
            if (tck_fall)
                tdo_o <= next_tdo;
            instruction_opcode_field_o <= test_instruction_register;
            dr_select_o                <= sel;
            bound_select_o             <= (sel == `SEL_BOUND);
            // mode lines share the opcode's clock; reserved codes raise none of them
            pins_highz_o   <= (test_instruction_register == `OP_HIGHZ);
            single_step_o  <= (test_instruction_register == `OP_INTEST);
            extest_o       <= (test_instruction_register == `OP_EXTEST);
        end
    end
endmodule

/* core/jtag_ir_dr_map.vh */
// constants for the test instruction and data register block
`ifndef JTAG_IR_DR_MAP_VH
`define JTAG_IR_DR_MAP_VH
`define IR_WIDTH        4
`define IR_RESET        4'h2
`define IR_CAPTURE      4'h1
`define OP_EXTEST       4'h0
`define OP_SAMPLE       4'h1
`define OP_DEVICE_IDENTIFICATION_REGISTER       4'h2
`define OP_HIGHZ        4'h8
`define OP_INTEST       4'h9
`define OP_BYPASS       4'hF
`define ID_WIDTH        32
`define ID_VER_MSB      31
`define ID_VER_LSB      28
`define ID_PN_MSB       27
`define ID_PN_LSB       12
`define ID_MFR_MSB      11
`define ID_MFR_LSB      1
`define ID_PRESENT_BIT  0
`define BYPASS_CAPTURE  1'b0
`define SEL_BYPASS      2'h0
`define SEL_IDENT       2'h1
`define SEL_BOUND       2'h2
`endif

/* core/tck_edge_detect.v */
// two-flop synchroniser and edge finder for the test clock pin
`timescale 1ns/1ps
module tck_edge_detect (
    input  wire sys_clk_i,
    input  wire srst_i,
    input  wire tck_i,
    output reg  rise_o,
    output reg  fall_o
);
    reg       sync1;
    reg       sync2;
    reg       sync3;
    reg [2:0] warm;

    // first flop feeds only the second; edges are found on later stages
    // warm masks edges until sync3 holds a real pin level, so reset makes no false edge;
    // only a level change before the first clock after reset is lost; later edges are all found
    always @(posedge sys_clk_i) begin
        if (srst_i) begin
            sync1  <= 1'b0;
            sync2  <= 1'b0;
            sync3  <= 1'b0;
            warm   <= 3'h0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            sync1  <= tck_i;
            sync2  <= sync1;
            sync3  <= sync2;
            warm   <= {warm[1:0], 1'b1};
            rise_o <= warm[2] & sync2 & ~sync3;
            fall_o <= warm[2] & ~sync2 & sync3;
        end
    end
endmodule

/* testbench/jtag_regs_properties.sv */
// concurrent checks on opcode decode and test reset
`timescale 1ns/1ps
module jtag_regs_properties (
    input wire       sys_clk_i,
    input wire       srst_i,
    input wire       trst_n_i,
    input wire       test_logic_reset_i,
    input wire [3:0] instruction_opcode_field_o,
    input wire [1:0] dr_select_o,
    input wire       bound_select_o,
    input wire       pins_highz_o,
    input wire       single_step_o,
    input wire       extest_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);
    // opcode and decode are registered together; two cycles keep off the change edge
    wire [3:0] op  = instruction_opcode_field_o;
    wire [5:0] dec = {dr_select_o, bound_select_o, pins_highz_o, single_step_o, extest_o};
    a_bypass_path: assert property ((op == 4'hF)[*2] |-> dec == 6'h00)
        else $error("bypass decode wrong");
    a_extest_path: assert property ((op == 4'h0)[*2] |-> dec == 6'h29)
        else $error("extest decode wrong");
    a_sample_path: assert property ((op == 4'h1)[*2] |-> dec == 6'h28)
        else $error("sample decode wrong");
    a_ident_path: assert property ((op == 4'h2)[*2] |-> dec == 6'h10)
        else $error("ident decode wrong");
    a_intest_path: assert property ((op == 4'h9)[*2] |-> dec == 6'h2A)
        else $error("intest decode wrong");
    a_highz_path: assert property ((op == 4'h8)[*2] |-> dec == 6'h04)
        else $error("highz decode wrong");
    // sync and opcode registers take four clocks, six leaves margin
    a_logic_reset_ident: assert property (test_logic_reset_i[*6] |-> op == 4'h2)
        else $error("logic reset opcode wrong");
    a_trst_ident: assert property ((!trst_n_i)[*6] |-> op == 4'h2)
        else $error("trst opcode wrong");
endmodule

/* testbench/jtag_test_controller.sv */
// test controller model walking tap state levels around tck edges
`timescale 1ns/1ps
module jtag_test_controller (
    input  wire       sys_clk_i,
    input  wire       tdo_i,
    output reg        tck_o = 1'b1,
    output reg        tdi_o = 1'b0,
    output reg  [5:0] state_o = 6'h00,
    output wire       bound_so_o
);
    reg [7:0] chain = 8'hA5;
    // boundary chain stand-in: fixed capture value, bit 0 nearest tdo
    always @(posedge tck_o)
        chain <= state_o[1] ? 8'hA5 : state_o[0] ? {tdi_o, chain[7:1]} : chain;
    assign bound_so_o = chain[0];
    // one 160 ns period; levels move mid-high so both edges see them steady
    task tick(input [5:0] s, input b, output t);
        repeat (4) @(negedge sys_clk_i);
        state_o = s;
        tdi_o = (s[3] | s[0]) ? b : ~tdi_o; // unused tdi toggles, no pull
        repeat (4) @(negedge sys_clk_i);
        tck_o = 1'b0;
        repeat (8) @(negedge sys_clk_i);
        t = tdo_i;
        tck_o = 1'b1;
    endtask
    // capture, shift n bits, exit, update on instruction scans only, idle
    task scan(input ir, input integer n, input [31:0] d, output [31:0] q);
        integer i;
        reg     t;
        q = 32'h0;
        tick(ir ? 6'h10 : 6'h02, 1'b0, t);
        for (i = 0; i < n; i = i + 1)
            tick(ir ? 6'h08 : 6'h01, d[i], q[i]);
        tick(6'h00, 1'b0, t);
        tick(ir ? 6'h04 : 6'h00, 1'b0, t);
        tick(6'h00, 1'b0, t);
    endtask
endmodule

/* testbench/jtag_instruction_and_data_regs_bench.sv */
// self-checking bench for the instruction and data register block
`timescale 1ns/1ps
module jtag_instruction_and_data_regs_bench;
    localparam [31:0] ID = {4'h3, 16'h1234, 11'h2AB, 1'b1}; // fields arbitrary
    reg        sys_clk_i = 1'b0;
    reg        srst_i = 1'b1;
    reg        trst_n_i = 1'b1;
    wire       tck, tdi, tdo, bso, bsel, hz, ss, ex;
    wire [5:0] st;
    wire [3:0] op;
    wire [1:0] sel;
    integer    error_cnt = 0;
    integer    comparisons = 0;
    integer    i;
    reg [31:0] q;
    reg [3:0]  ops [0:5];
    reg [5:0]  dec [0:5];
    reg [31:0] dr [0:5];
    jtag_instruction_and_data_regs #(.VERSION_FIELD(4'h3), .PART_NUMBER_FIELD(16'h1234),
        .MAKER_CODE_FIELD(11'h2AB)) u_jtag_instruction_and_data_regs (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .tck_i(tck), .tdi_i(tdi),
        .trst_n_i(trst_n_i), .test_logic_reset_i(st[5]), .capture_ir_i(st[4]),
        .shift_ir_i(st[3]), .update_ir_i(st[2]), .capture_dr_i(st[1]), .shift_dr_i(st[0]),
        .bound_so_i(bso), .tdo_o(tdo), .instruction_opcode_field_o(op), .dr_select_o(sel),
        .bound_select_o(bsel), .pins_highz_o(hz), .single_step_o(ss), .extest_o(ex));
    jtag_test_controller u_jtag_test_controller (.sys_clk_i(sys_clk_i), .tdo_i(tdo),
        .tck_o(tck), .tdi_o(tdi), .state_o(st), .bound_so_o(bso));
    always #5 sys_clk_i = ~sys_clk_i;
    task check(input [31:0] got, input [31:0] want);
        comparisons = comparisons + 1;
        if (got !== want) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    task final_report;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // defined opcodes only; bypass shows tdi one bit late, chain after eight
    initial begin
        {ops[0], ops[1], ops[2], ops[3], ops[4], ops[5]} = {16'h0198, 8'hF2};
        {dec[0], dec[1], dec[2], dec[3], dec[4], dec[5]} = {24'hA68A84, 12'h010};
        {dr[0], dr[1], dr[2], dr[3], dr[4], dr[5]} = {{3{32'h1A5}}, {2{32'h2}}, ID};
        repeat (3) @(negedge sys_clk_i);
        srst_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        check({28'h0, op}, 32'h2);
        u_jtag_test_controller.scan(1'b0, 32, 32'h0, q);
        check(q, ID);
        for (i = 0; i < 6; i = i + 1) begin
            u_jtag_test_controller.scan(1'b1, 4, {28'h0, ops[i]}, q);
            check(q, 32'h1);
            check({28'h0, op}, {28'h0, ops[i]});
            check({26'h0, sel, bsel, hz, ss, ex}, {26'h0, dec[i]});
            u_jtag_test_controller.scan(1'b0, 32, 32'h1, q);
            check(q, dr[i]);
        end
        u_jtag_test_controller.scan(1'b1, 4, 32'h8, q);
        check({28'h0, op}, 32'h8);
        u_jtag_test_controller.tick(6'h20, 1'b0, q[0]);
        u_jtag_test_controller.tick(6'h20, 1'b0, q[0]);
        check({28'h0, op}, 32'h2);
        u_jtag_test_controller.scan(1'b0, 32, 32'h0, q);
        check(q, ID);
        u_jtag_test_controller.scan(1'b1, 4, 32'hF, q);
        check(q, 32'h1);
        check({28'h0, op}, 32'hF);
        trst_n_i = 1'b0;
        repeat (8) @(negedge sys_clk_i);
        trst_n_i = 1'b1;
        repeat (2) @(negedge sys_clk_i);
        check({28'h0, op}, 32'h2);
        u_jtag_test_controller.scan(1'b0, 32, 32'h0, q);
        check(q, ID);
        final_report;
    end
    // cut a hang short
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        error_cnt = error_cnt + 1;
        final_report;
    end
endmodule
bind jtag_instruction_and_data_regs jtag_regs_properties u_jtag_regs_properties (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .trst_n_i(trst_n_i),
    .test_logic_reset_i(test_logic_reset_i),
    .instruction_opcode_field_o(instruction_opcode_field_o),
    .dr_select_o(dr_select_o), .bound_select_o(bound_select_o), .pins_highz_o(pins_highz_o),
    .single_step_o(single_step_o), .extest_o(extest_o));
